// File: rtl/uoirq_pkg.sv
// shared constants and carriers for the interrupt mask and receive status block
package uoirq_pkg;

	// ******************************************************************
	// register offsets (byte addresses)
	// ******************************************************************
	localparam logic [11:0] OFS_CORE_INTERRUPT_MASK = 12'h018; // mask register
	localparam logic [11:0] OFS_RECEIVE_STATUS_PEEK = 12'h01C; // top entry, no pop
	localparam logic [11:0] OFS_RECEIVE_STATUS_POP  = 12'h020; // top entry with pop
	localparam logic [11:0] OFS_ROLE_STATUS         = 12'h0F0; // role / mismatch / fill

	// ******************************************************************
	// reset values and mask bit groups
	// ******************************************************************
	localparam logic [31:0] MASK_RESET     = 32'h0000_0000; // all sources masked
	localparam logic [31:0] MASK_HOST_ONLY = 32'h0700_0020; // bits 26,25,24,5
	localparam logic [31:0] MASK_DEV_ONLY  = 32'h201E_FCC0; // 29,20:17,15:10,7:6
	localparam logic [31:0] MASK_BOTH      = 32'hD020_001E; // 31,30,28,21,4:1
	localparam logic [31:0] MASK_WRITABLE  = 32'hF73E_FCFE; // reserved bits stay zero
	localparam logic [31:0] EMPTY_READ     = 32'h0000_0000; // answer of an empty fifo

	// ******************************************************************
	// status bit positions
	// ******************************************************************
	localparam int BIT_ROLE      = 0; // current role: 0 device, 1 host
	localparam int BIT_MISMATCH  = 1; // mode mismatch
	localparam int BIT_RX_NEMPTY = 4; // receive fifo non-empty

	// ******************************************************************
	// receive status field layout
	// ******************************************************************
	localparam int POS_NUMBER = 0;  // channel / endpoint number, 3:0
	localparam int POS_BYTE_COUNT   = 4;  // byte count, 14:4
	localparam int POS_PID    = 15; // data pid, 16:15
	localparam int POS_PACKET_STATUS = 17; // packet status, 20:17
	localparam int POS_FRAME  = 21; // device frame number low bits, 24:21

	// ******************************************************************
	// encodings
	// ******************************************************************
	localparam logic [1:0] PID_DATA0 = 2'h0; // 00
	localparam logic [1:0] PID_DATA1 = 2'h2; // 10
	localparam logic [1:0] PID_DATA2 = 2'h1; // 01
	localparam logic [1:0] PID_MDATA = 2'h3; // 11
	localparam logic [3:0] HST_IN_DATA     = 4'h2; // in data received
	localparam logic [3:0] HST_IN_DONE     = 4'h3; // in transfer completed
	localparam logic [3:0] HST_TOGGLE_ERR  = 4'h5; // data toggle error
	localparam logic [3:0] HST_CH_HALTED   = 4'h7; // channel halted
	localparam logic [3:0] DEV_GLOBAL_NAK  = 4'h1; // global out nak
	localparam logic [3:0] DEV_OUT_DATA    = 4'h2; // out data received
	localparam logic [3:0] DEV_OUT_DONE    = 4'h3; // out transfer completed
	localparam logic [3:0] DEV_SETUP_DONE  = 4'h4; // setup transaction completed
	localparam logic [3:0] DEV_SETUP_DATA  = 4'h6; // setup data received

	// ******************************************************************
	// sizes
	// ******************************************************************
	localparam int FIFO_DEPTH  = 16; // receive status entries
	localparam int ENTRY_WIDTH = 25; // bits of one entry

	// one receive status entry as the protocol engine pushes it
	typedef struct packed {
		logic [3:0]  frame_number_low; // low frame bits, device only
		logic [3:0]  packet_status;    // packet status code
		logic [1:0]  data_pid_field;   // data pid code
		logic [10:0] byte_count;       // bytes in packet
		logic [3:0]  number;           // channel or endpoint number
	} uoirq_rx_entry_t;

	// one register bus request
	typedef struct packed {
		logic        sel;   // access this cycle
		logic        write; // 1 write, 0 read
		logic [11:0] addr;  // byte address
		logic [31:0] wdata; // write data
	} uoirq_bus_req_t;

endpackage

// File: rtl/uoirq_mem.sv
// small dual-port memory with registered read data and write bypass
`timescale 1ns/100ps
module uoirq_mem #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] store [DEPTH]; // entry storage
	logic [WIDTH-1:0] rdata_next;    // next read word

	// bypass keeps the read word current when it is written in the same cycle
	always_comb
	begin
		rdata_next = store[raddr];
		if (we && (waddr == raddr))
		begin
			rdata_next = wdata;
		end
	end

	// storage and read register; no reset needed for plain data
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			store[waddr] <= wdata;
		end
		rdata <= rdata_next;
	end
endmodule

// File: rtl/uoirq_fifo.sv
// show-ahead fifo with valid and ready on both sides
`timescale 1ns/100ps
module uoirq_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = AW'(DEPTH) == '0 ? (AW+1)'(DEPTH) : (AW+1)'(DEPTH);

	logic [AW-1:0] wr_ptr_reg, wr_ptr_next; // next slot to fill
	logic [AW-1:0] rd_ptr_reg, rd_ptr_next; // slot at head
	logic [AW:0]   count_reg,  count_next;  // stored entries
	logic          push, pop;               // handshakes

	// ******************************************************************
	// pointer and count update
	// ******************************************************************
	always_comb
	begin
		push        = in_valid && (count_reg != FULL_COUNT);
		pop         = out_ready && (count_reg != '0);
		wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
		count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	// registers only
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	// flags come from the count register, so they are honest every cycle
	assign in_ready  = (count_reg != FULL_COUNT);
	assign out_valid = (count_reg != '0);

	// read address looks one step ahead so the head word is ready after a pop
	uoirq_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.clk   (clk),
		.we    (push),
		.waddr (wr_ptr_reg),
		.wdata (in_data),
		.raddr (rd_ptr_next),
		.rdata (out_data)
	);
endmodule

// File: rtl/uoirq_top.sv
// interrupt mask register, irq gating and receive status peek/pop ports
// Function
// - masked sources raise no request; status still sets
// - mask at 0x018, resets zero, 1 unmasks
// - host-only bits 26,25,24,5 work in host
// - device-only bits 29,20:17,15:10,7:6 work in device
// - bits 31,30,28,4,3,2,1 work in both roles
// - bit 21 masks periodic or iso out
// - read at 0x01C shows top entry only
// - read at 0x020 shows and pops top
// - empty fifo reads zero, nothing changes
// - status layout follows the current role
// - host layout packet_status,pid,byte_count,channel; upper bits zero
// - host packet status codes 2,3,5,7
// - pid codes data0 00, data1 10, data2 01
// - device layout adds frame bits 24:21
// - frame field carries frame low four bits
// - device packet status codes 1,2,3,4,6
// - role bit reads 0 device, 1 host
// - non-empty flag set while entries wait
// - foreign-role access is harmless, sets mismatch
`timescale 1ns/100ps
module uoirq_top
	import uoirq_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire uoirq_pkg::uoirq_bus_req_t  bus_req,
	output logic                            bus_ack,
	output logic [31:0]                     bus_rdata,
	input  wire logic [31:0]                core_status_in,
	input  wire logic                       role_host_pin,
	input  wire logic                       host_reg_access,
	input  wire logic                       device_reg_access,
	input  wire logic                       rx_entry_valid,
	input  wire uoirq_pkg::uoirq_rx_entry_t rx_entry,
	output logic                            rx_entry_ready,
	output logic                            rx_nonempty_flag,
	output logic                            current_role,
	output logic                            irq
);
	import uoirq_pkg::*;

	// ******************************************************************
	// declarations
	// ******************************************************************
	logic [31:0]     core_interrupt_mask_reg, core_interrupt_mask_next; // mask register
	logic            mismatch_reg,   mismatch_next;   // sticky mode mismatch
	logic            role_s1_reg,    role_s2_reg, role_s3_reg; // role synchroniser
	logic            role_reg,       role_next;       // settled role
	logic            bus_ack_reg,    bus_ack_next;    // answer strobe
	logic [31:0]     bus_rdata_reg,  bus_rdata_next;  // read answer
	logic            irq_reg,        irq_next;        // interrupt line
	logic            ready_reg,      ready_next;      // fifo room, registered
	logic            nempty_reg,     nempty_next;     // fifo fill, registered
	logic            fifo_in_ready;                   // fifo room now
	logic            fifo_out_valid;                  // fifo holds an entry
	logic [ENTRY_WIDTH-1:0] fifo_out_data;            // head entry bits
	uoirq_rx_entry_t head;                            // head entry fields
	logic            fifo_pop;                        // pop request
	logic            rd_acc, wr_acc;                  // decoded access kind
	logic [31:0]     status_eff;                      // status as seen by irq
	logic [31:0]     mask_eff;                        // mask after role gating

	// ******************************************************************
	// helpers
	// ******************************************************************

	// offset compare used by every decode branch
	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
		addr_is = (a == ofs);
	endfunction

	// build the status word in the layout of the current role
	function automatic logic [31:0] format_entry(input uoirq_rx_entry_t e,
		input logic host);
		logic [31:0] w;
		w = '0;
		w[POS_NUMBER +: 4]  = e.number;
		w[POS_BYTE_COUNT   +: 11] = e.byte_count;
		w[POS_PID    +: 2]  = e.data_pid_field; // codes pass untouched
		w[POS_PACKET_STATUS +: 4]  = e.packet_status;  // codes pass untouched
		if (!host)
		begin
			w[POS_FRAME +: 4] = e.frame_number_low;
		end
		format_entry = w; // host upper bits stay zero
	endfunction

	assign head = uoirq_rx_entry_t'(fifo_out_data);

	// ******************************************************************
	// role input synchroniser
	// ******************************************************************

	// the role comes from outside the clock domain: three stages, change when two agree
	always_comb
	begin
		role_next = role_reg;
		if (role_s2_reg == role_s3_reg)
		begin
			role_next = role_s3_reg;
		end
	end

	// registers only
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			role_s1_reg <= 1'b0;
			role_s2_reg <= 1'b0;
			role_s3_reg <= 1'b0;
			role_reg    <= 1'b0;
		end
		else
		begin
			role_s1_reg <= role_host_pin;
			role_s2_reg <= role_s1_reg;
			role_s3_reg <= role_s2_reg;
			role_reg    <= role_next;
		end
	end

	// ******************************************************************
	// register bus decode
	// ******************************************************************

	// a single-cycle request; the answer follows on the next edge
	always_comb
	begin
		rd_acc                   = bus_req.sel && !bus_req.write;
		wr_acc                   = bus_req.sel && bus_req.write;
		core_interrupt_mask_next = core_interrupt_mask_reg;
		mismatch_next            = mismatch_reg;
		bus_ack_next             = bus_req.sel;
		bus_rdata_next           = '0; // unmapped reads answer zero
		fifo_pop                 = 1'b0;
		if (addr_is(bus_req.addr, OFS_CORE_INTERRUPT_MASK))
		begin
			if (wr_acc)
			begin
				// reserved bits are dropped even if software sets them
				core_interrupt_mask_next = bus_req.wdata & MASK_WRITABLE;
			end
			bus_rdata_next = core_interrupt_mask_reg;
		end
		else if (addr_is(bus_req.addr, OFS_RECEIVE_STATUS_PEEK))
		begin
			// look only, the head stays put
			if (rd_acc && fifo_out_valid)
			begin
				bus_rdata_next = format_entry(head, role_reg);
			end
		end
		else if (addr_is(bus_req.addr, OFS_RECEIVE_STATUS_POP))
		begin
			// pop in the same access; an empty fifo is left alone
			if (rd_acc && fifo_out_valid)
			begin
				bus_rdata_next = format_entry(head, role_reg);
				fifo_pop       = 1'b1;
			end
			else
			begin
				bus_rdata_next = EMPTY_READ;
			end
		end
		else if (addr_is(bus_req.addr, OFS_ROLE_STATUS))
		begin
			if (wr_acc && bus_req.wdata[BIT_MISMATCH])
			begin
				mismatch_next = 1'b0; // write one clears
			end
			bus_rdata_next[BIT_ROLE]      = role_reg;
			bus_rdata_next[BIT_MISMATCH]  = mismatch_reg;
			bus_rdata_next[BIT_RX_NEMPTY] = nempty_reg;
		end
		// between accesses the answer word stands still
		if (!bus_req.sel)
		begin
			bus_rdata_next = bus_rdata_reg;
		end
		// foreign role access elsewhere in the map: only the flag moves, set wins
		if ((host_reg_access && !role_reg) || (device_reg_access && role_reg))
		begin
			mismatch_next = 1'b1;
		end
	end

	// registers only
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			core_interrupt_mask_reg <= MASK_RESET; // all masked at start
			mismatch_reg            <= 1'b0;
			bus_ack_reg             <= 1'b0;
			bus_rdata_reg           <= '0;
		end
		else
		begin
			core_interrupt_mask_reg <= core_interrupt_mask_next;
			mismatch_reg            <= mismatch_next;
			bus_ack_reg             <= bus_ack_next;
			bus_rdata_reg           <= bus_rdata_next;
		end
	end

	// ******************************************************************
	// interrupt gating
	// ******************************************************************

	// status bits set regardless of the mask; only the request is gated
	always_comb
	begin
		status_eff                = core_status_in;
		status_eff[BIT_ROLE]      = 1'b0; // role bit is no event
		status_eff[BIT_MISMATCH]  = mismatch_reg;
		status_eff[BIT_RX_NEMPTY] = fifo_out_valid;
		// role-specific bits count only in their own role
		mask_eff = core_interrupt_mask_reg &
			(role_reg ? (MASK_HOST_ONLY | MASK_BOTH) : (MASK_DEV_ONLY | MASK_BOTH));
		irq_next = |(status_eff & mask_eff);
	end

	// ******************************************************************
	// fifo flags
	// ******************************************************************

	// flags are registered copies; the push uses the fifo's own ready, so an entry offered the cycle after the fifo fills is dropped
	always_comb
	begin
		ready_next  = fifo_in_ready;
		nempty_next = fifo_out_valid;
	end

	// registers only
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			irq_reg    <= 1'b0;
			ready_reg  <= 1'b0;
			nempty_reg <= 1'b0;
		end
		else
		begin
			irq_reg    <= irq_next;
			ready_reg  <= ready_next;
			nempty_reg <= nempty_next;
		end
	end

	// ******************************************************************
	// receive status fifo
	// ******************************************************************

	// entries are taken only while the registered ready is high, which lags one
	// cycle; the fifo gates its own push, so a late push is simply not taken
	uoirq_fifo #(.WIDTH(ENTRY_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (rx_entry_valid && ready_reg),
		.in_data   (rx_entry),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (fifo_pop)
	);

	// ******************************************************************
	// outputs
	// ******************************************************************
	assign bus_ack          = bus_ack_reg;
	assign bus_rdata        = bus_rdata_reg;
	assign rx_entry_ready   = ready_reg;
	assign rx_nonempty_flag = nempty_reg;
	assign current_role     = role_reg;
	assign irq              = irq_reg;
endmodule

// File: test/uoirq_top_assertions.sv
// port-level checks for the interrupt mask and receive status block
`timescale 1ns/100ps
module uoirq_top_assertions
	import uoirq_pkg::*;
(
	input wire logic                       clk,
	input wire logic                       srst,
	input wire uoirq_pkg::uoirq_bus_req_t  bus_req,
	input wire logic                       bus_ack,
	input wire logic [31:0]                bus_rdata,
	input wire logic [31:0]                core_status_in,
	input wire logic                       role_host_pin,
	input wire logic                       host_reg_access,
	input wire logic                       device_reg_access,
	input wire logic                       rx_entry_valid,
	input wire uoirq_pkg::uoirq_rx_entry_t rx_entry,
	input wire logic                       rx_entry_ready,
	input wire logic                       rx_nonempty_flag,
	input wire logic                       current_role,
	input wire logic                       irq
);
	// ******************************************************************
	// helper state and sequences
	// ******************************************************************
	logic mask_set_reg;  // a nonzero mask write has been seen
	logic mask_set_next; // next value of the above

	// only weakens the irq check: a later zero write keeps it set
	always_comb
	begin
		mask_set_next = mask_set_reg | (bus_req.sel & bus_req.write
			& (bus_req.addr == OFS_CORE_INTERRUPT_MASK) & (bus_req.wdata != 32'h0));
	end

	// reset clears it together with the mask itself
	always_ff @(posedge clk)
	begin
		mask_set_reg <= srst ? 1'b0 : mask_set_next;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// a read of the peek or pop place
	sequence s_rx_read;
		bus_req.sel && !bus_req.write && (bus_req.addr == OFS_RECEIVE_STATUS_PEEK
			|| bus_req.addr == OFS_RECEIVE_STATUS_POP);
	endsequence

	// the fifo was surely empty: flag low and no push one edge back
	sequence s_known_empty;
		!rx_nonempty_flag && !$past(rx_entry_valid && rx_entry_ready);
	endsequence

	// ******************************************************************
	// assertions
	// ******************************************************************
	a_ack_timing: assert property (bus_ack == $past(bus_req.sel))
		else $error("bus_ack not one cycle after sel");
	a_empty_read_zero: assert property (s_rx_read ##0 s_known_empty |=> bus_rdata == EMPTY_READ)
		else $error("empty receive read not zero");
	a_irq_held_masked: assert property (!mask_set_reg |-> !irq)
		else $error("irq raised with all sources masked");
	a_push_sets_flag: assert property (rx_entry_valid && rx_entry_ready |=> ##1 rx_nonempty_flag)
		else $error("non-empty flag missing after push");
	a_role_follows_pin: assert property ($stable(role_host_pin)[*8] |-> current_role == role_host_pin)
		else $error("current_role differs from steady pin");
	a_rdata_holds: assert property (!bus_ack |-> $stable(bus_rdata))
		else $error("bus_rdata changed without an answer");
	a_mask_reserved: assert property (bus_req.sel && !bus_req.write
		&& bus_req.addr == OFS_CORE_INTERRUPT_MASK |=> (bus_rdata & ~MASK_WRITABLE) == 32'h0)
		else $error("reserved mask bit reads nonzero");
	a_host_upper_zero: assert property (s_rx_read ##0 current_role |=> bus_rdata[31:21] == 11'h000)
		else $error("host status upper bits nonzero");
	a_dev_upper_zero: assert property (s_rx_read ##0 !current_role |=> bus_rdata[31:25] == 7'h00)
		else $error("device status upper bits nonzero");
endmodule

// File: test/uoirq_top_tb_top.sv
// self-checking bench for the interrupt mask and receive status block
`timescale 1ns/100ps
module uoirq_top_tb_top;
	import uoirq_pkg::*;
	logic            clk = 1'b0;          // 25 MHz
	logic            srst = 1'b1;         // sync reset
	uoirq_bus_req_t  bus_req = '0;        // register request
	logic            bus_ack;             // register answer
	logic [31:0]     bus_rdata;           // read data
	logic [31:0]     core_status_in = '0; // interrupt sources
	logic            role_host_pin = 1'b0;
	logic            host_reg_access = 1'b0;
	logic            device_reg_access = 1'b0;
	logic            rx_entry_valid = 1'b0;
	uoirq_rx_entry_t rx_entry = '0;
	logic            rx_entry_ready;
	logic            rx_nonempty_flag;
	logic            current_role;
	logic            irq;
	int              n_errors = 0;        // mismatches
	int              comparisons = 0;     // checks made

	always #20 clk = ~clk;

	uoirq_top uut (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .core_status_in(core_status_in), .role_host_pin(role_host_pin),
		.host_reg_access(host_reg_access), .device_reg_access(device_reg_access),
		.rx_entry_valid(rx_entry_valid), .rx_entry(rx_entry), .rx_entry_ready(rx_entry_ready),
		.rx_nonempty_flag(rx_nonempty_flag), .current_role(current_role), .irq(irq));

	// ******************************************************************
	// shared tasks
	// ******************************************************************
	task summarize;
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task chk1(input string name, input logic exp, input logic got);
		chk32(name, {31'h0, exp}, {31'h0, got});
	endtask

	// one access: sel for one cycle, answer registered at the taking edge
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		bit got;
		got = 0;
		@(posedge clk);
		bus_req <= '{sel: 1'b1, write: wr, addr: a, wdata: wd};
		@(posedge clk);
		bus_req.sel <= 1'b0;
		// the answer stands for one cycle right after the taking edge
		for (int i = 0; i < 4 && !got; i++)
		begin
			#1 got = (bus_ack === 1'b1);
			if (!got)
				@(posedge clk);
		end
		if (!got)
		begin
			n_errors++;
			summarize();
		end
		else
			rd = bus_rdata;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk32(name, exp, x);
	endtask

	// valid stays up until an edge that saw ready high
	task push(input uoirq_rx_entry_t e);
		bit ok;
		ok = 0;
		@(posedge clk);
		rx_entry_valid <= 1'b1;
		rx_entry <= e;
		for (int i = 0; i < 40 && !ok; i++)
		begin
			#1 ok = (rx_entry_ready === 1'b1);
			@(posedge clk);
		end
		rx_entry_valid <= 1'b0;
		if (!ok)
		begin
			n_errors++;
			summarize();
		end
	endtask

	// expected status word, built field by field for each role
	function automatic logic [31:0] fmt(input uoirq_rx_entry_t e, input logic h);
		if (h)
			return {11'h000, e.packet_status, e.data_pid_field, e.byte_count, e.number};
		return {7'h00, e.frame_number_low, e.packet_status, e.data_pid_field,
			e.byte_count, e.number};
	endfunction

	task set_role(input logic h);
		@(posedge clk) role_host_pin <= h;
		repeat (8) @(posedge clk);
		#1 chk1("current_role", h, current_role);
	endtask

	// ******************************************************************
	// scenarios
	// ******************************************************************
	task t_reset_values;
		rd_chk("mask_reset", OFS_CORE_INTERRUPT_MASK, 32'h0000_0000);
		rd_chk("peek_empty", OFS_RECEIVE_STATUS_PEEK, 32'h0000_0000);
		rd_chk("pop_empty", OFS_RECEIVE_STATUS_POP, 32'h0000_0000);
		rd_chk("role_status", OFS_ROLE_STATUS, 32'h0000_0000);
		@(posedge clk) core_status_in <= 32'hFFFF_FFFF;
		repeat (3) @(posedge clk);
		#1 chk1("irq_all_masked", 1'b0, irq);
		wr(OFS_CORE_INTERRUPT_MASK, 32'hFFFF_FFFF);
		rd_chk("mask_reserved", OFS_CORE_INTERRUPT_MASK, 32'hF73E_FCFE);
		wr(OFS_CORE_INTERRUPT_MASK, 32'h0000_0000);
	endtask

	// one source at a time, unmasked then masked, in the given role
	task t_gating(input logic h);
		logic [31:0] ok_bits;
		ok_bits = h ? 32'hD720_002C : 32'hF03E_FCCC;
		set_role(h);
		for (int b = 2; b < 32; b++)
		begin
			if (b != 4 && !(32'h08C1_0301 >> b & 32'h1))
			begin
				@(posedge clk) core_status_in <= 32'h1 << b;
				wr(OFS_CORE_INTERRUPT_MASK, 32'h1 << b);
				repeat (2) @(posedge clk);
				#1 chk1("irq_unmasked", ok_bits[b], irq);
				wr(OFS_CORE_INTERRUPT_MASK, 32'h0);
				repeat (2) @(posedge clk);
				#1 chk1("irq_masked", 1'b0, irq);
			end
		end
		@(posedge clk) core_status_in <= 32'h0;
	endtask

	// fill the fifo with 16 entries, check that it refuses more, then peek and pop every entry
	task t_rx(input logic h);
		uoirq_rx_entry_t e [16];
		logic [3:0]      hc [4];
		logic [3:0]      dc [5];
		hc = '{HST_IN_DATA, HST_IN_DONE, HST_TOGGLE_ERR, HST_CH_HALTED};
		dc = '{DEV_GLOBAL_NAK, DEV_OUT_DATA, DEV_OUT_DONE, DEV_SETUP_DONE, DEV_SETUP_DATA};
		set_role(h);
		wr(OFS_CORE_INTERRUPT_MASK, 32'h0000_0010);
		for (int i = 0; i < 16; i++)
		begin
			e[i] = '{frame_number_low: i[3:0], packet_status: h ? hc[i % 4] : dc[i % 5],
				data_pid_field: i[1:0], byte_count: 11'h7FF - i[10:0], number: ~i[3:0]};
			push(e[i]);
		end
		repeat (2) @(posedge clk);
		#1 chk1("ready_full", 1'b0, rx_entry_ready);
		chk1("nonempty_full", 1'b1, rx_nonempty_flag);
		chk1("irq_rx", 1'b1, irq);
		for (int i = 0; i < 16; i++)
		begin
			rd_chk("peek", OFS_RECEIVE_STATUS_PEEK, fmt(e[i], h));
			rd_chk("pop", OFS_RECEIVE_STATUS_POP, fmt(e[i], h));
		end
		repeat (3) @(posedge clk);
		#1 chk1("nonempty_drained", 1'b0, rx_nonempty_flag);
		chk1("irq_drained", 1'b0, irq);
		rd_chk("pop_drained", OFS_RECEIVE_STATUS_POP, 32'h0000_0000);
		wr(OFS_CORE_INTERRUPT_MASK, 32'h0);
	endtask

	// a host register touched in device role flags a mismatch
	task t_mismatch;
		set_role(1'b0);
		wr(OFS_CORE_INTERRUPT_MASK, 32'h0000_0002);
		@(posedge clk) device_reg_access <= 1'b1;
		@(posedge clk) device_reg_access <= 1'b0;
		rd_chk("own_role_access", OFS_ROLE_STATUS, 32'h0000_0000);
		@(posedge clk) host_reg_access <= 1'b1;
		@(posedge clk) host_reg_access <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk1("irq_mismatch", 1'b1, irq);
		rd_chk("mismatch_set", OFS_ROLE_STATUS, 32'h0000_0002);
		wr(OFS_ROLE_STATUS, 32'h0000_0002);
		rd_chk("mismatch_clear", OFS_ROLE_STATUS, 32'h0000_0000);
		rd_chk("unmapped", 12'h0F8, 32'h0000_0000);
		#1 chk1("irq_cleared", 1'b0, irq);
	endtask

	// reset for six cycles, then the scenarios in turn
	initial
	begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset_values();
		t_gating(1'b0);
		t_gating(1'b1);
		t_rx(1'b1);
		t_rx(1'b0);
		t_mismatch();
		summarize();
	end
endmodule

bind uoirq_top uoirq_top_assertions u_chk (.clk(clk), .srst(srst), .bus_req(bus_req),
	.bus_ack(bus_ack), .bus_rdata(bus_rdata), .core_status_in(core_status_in),
	.role_host_pin(role_host_pin), .host_reg_access(host_reg_access),
	.device_reg_access(device_reg_access), .rx_entry_valid(rx_entry_valid),
	.rx_entry(rx_entry), .rx_entry_ready(rx_entry_ready),
	.rx_nonempty_flag(rx_nonempty_flag), .current_role(current_role), .irq(irq));
